// file: include/bitbr_pkg.sv
// Package for the carry bit logic and branch evaluation block.
// Holds operation codes, condition codes, widths and register map.
package bitbr_pkg;

    // Operation codes from the decoder
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_CARRY_OR_BIT = 5'h01,
        OP_CARRY_OR_INVERTED_BIT = 5'h02,
        OP_CARRY_XOR_BIT = 5'h03,
        OP_CARRY_XOR_INVERTED_BIT = 5'h04,
        OP_BIT_TO_CARRY_LOAD = 5'h05,
        OP_INVERTED_BIT_TO_CARRY_LOAD = 5'h06,
        OP_CARRY_TO_BIT_STORE = 5'h07,
        OP_INVERTED_CARRY_TO_BIT_STORE = 5'h08,
        OP_COND_BRANCH = 5'h09,
        OP_UNCONDITIONAL_JUMP = 5'h0a,
        OP_RELATIVE_SUBROUTINE_CALL = 5'h0b,
        OP_ABSOLUTE_SUBROUTINE_CALL = 5'h0c,
        OP_SUBROUTINE_RETURN = 5'h0d
    } op_t;

    // Branch condition field encodings
    typedef enum logic [3:0] {
        CC_BRANCH_ALWAYS = 4'h0,
        CC_BRANCH_NEVER = 4'h1,
        CC_BRANCH_UNSIGNED_HIGHER = 4'h2,
        CC_BRANCH_LOWER_OR_SAME = 4'h3,
        CC_BRANCH_CARRY_CLEAR = 4'h4,
        CC_BRANCH_CARRY_SET = 4'h5,
        CC_BRANCH_NOT_EQUAL = 4'h6,
        CC_BRANCH_EQUAL = 4'h7,
        CC_BRANCH_OVERFLOW_CLEAR = 4'h8,
        CC_BRANCH_OVERFLOW_SET = 4'h9,
        CC_BRANCH_PLUS = 4'ha,
        CC_BRANCH_MINUS = 4'hb,
        CC_BRANCH_SIGNED_GE = 4'hc,
        CC_BRANCH_SIGNED_LT = 4'hd,
        CC_BRANCH_SIGNED_GT = 4'he,
        CC_BRANCH_SIGNED_LE = 4'hf
    } cond_t;

    // Widths
    localparam int ADDR_W = 24;
    localparam int DEPTH_W = 3;
    localparam logic [ADDR_W-1:0] PC_RESET = 24'h000000;
    localparam logic [7:0] DEPTH_MAX = 8'h08;

    // Wishbone register offsets (word index x4)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_PC = 4'h8;
    localparam logic [3:0] REG_DEPTH = 4'hc;
    // Field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STAT_C_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    localparam int STAT_UNF_BIT = 2;
    localparam int STAT_TAKEN_BIT = 3;

    // Instruction from the decoder
    typedef struct packed {
        op_t op;
        cond_t cond;
        logic [2:0] bit_imm;
        logic bit_from_reg;
        logic [7:0] bit_reg;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] next_pc;
    } instr_t;

    // Flags from the condition code register
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_t;

endpackage

// file: logic/carry_bit_branch.sv
// Carry bit operations and branch, jump, call and return evaluation.
// Assumes decoder strobes one instruction at a time with operand byte,
// flags and target ready in the same cycle; results appear next cycle, a cycle later for a return from a non-empty stack.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module carry_bit_branch
    import bitbr_pkg::*;
#(
    parameter int STACK_AW = DEPTH_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Decoder side
    input wire logic exec_i,
    input wire instr_t instr_i,
    input wire flags_t flags_i,
    input wire logic [7:0] operand_i,
    // Results
    output logic carry_we_o,
    output logic carry_o,
    output logic byte_we_o,
    output logic [7:0] byte_o,
    output logic pc_we_o,
    output logic [ADDR_W-1:0] pc_o,
    output logic done_o,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    // --------------------------------------------------------------
    // Operand bit selection
    // --------------------------------------------------------------
    logic inverted;
    logic [2:0] bit_no;
    logic sel_bit;
    logic c_in;
    logic [7:0] bit_mask;

    // Inverted variants always use the immediate field
    always_comb begin
        inverted = (instr_i.op == OP_CARRY_OR_INVERTED_BIT) ||
                   (instr_i.op == OP_CARRY_XOR_INVERTED_BIT) ||
                   (instr_i.op == OP_INVERTED_BIT_TO_CARRY_LOAD) ||
                   (instr_i.op == OP_INVERTED_CARRY_TO_BIT_STORE);
        if (instr_i.bit_from_reg && !inverted) begin
            bit_no = instr_i.bit_reg[2:0];
        end else begin
            bit_no = instr_i.bit_imm;
        end
        sel_bit = operand_i[bit_no];
        c_in = flags_i.c;
        bit_mask = 8'h01 << bit_no;
    end

    // --------------------------------------------------------------
    // Branch condition
    // --------------------------------------------------------------
    logic cond_true;
    logic nxv;

    always_comb begin
        nxv = flags_i.n ^ flags_i.v;
        unique case (instr_i.cond)
            CC_BRANCH_ALWAYS: cond_true = 1'b1;
            CC_BRANCH_NEVER: cond_true = 1'b0;
            CC_BRANCH_UNSIGNED_HIGHER:
                cond_true = !(flags_i.c | flags_i.z);
            CC_BRANCH_LOWER_OR_SAME:
                cond_true = flags_i.c | flags_i.z;
            CC_BRANCH_CARRY_CLEAR: cond_true = !flags_i.c;
            CC_BRANCH_CARRY_SET: cond_true = flags_i.c;
            CC_BRANCH_NOT_EQUAL: cond_true = !flags_i.z;
            CC_BRANCH_EQUAL: cond_true = flags_i.z;
            CC_BRANCH_OVERFLOW_CLEAR: cond_true = !flags_i.v;
            CC_BRANCH_OVERFLOW_SET: cond_true = flags_i.v;
            CC_BRANCH_PLUS: cond_true = !flags_i.n;
            CC_BRANCH_MINUS: cond_true = flags_i.n;
            CC_BRANCH_SIGNED_GE: cond_true = !nxv;
            CC_BRANCH_SIGNED_LT: cond_true = nxv;
            CC_BRANCH_SIGNED_GT: cond_true = !(flags_i.z | nxv);
            CC_BRANCH_SIGNED_LE: cond_true = flags_i.z | nxv;
        endcase
    end

    // --------------------------------------------------------------
    // Control register and return stack bookkeeping
    // --------------------------------------------------------------
    logic enable_reg;
    logic [STACK_AW:0] depth_reg;
    logic ovf_reg;
    logic unf_reg;
    logic taken_reg;
    logic go;
    logic is_call;
    logic is_ret;
    logic push;
    logic pop;
    logic [STACK_AW-1:0] top_idx;
    logic [ADDR_W-1:0] stack_rdata;
    logic ret_pend_reg;
    logic wb_wr;

    assign go = exec_i && enable_reg && !ret_pend_reg;
    assign is_call = (instr_i.op == OP_RELATIVE_SUBROUTINE_CALL) ||
                     (instr_i.op == OP_ABSOLUTE_SUBROUTINE_CALL);
    assign is_ret = instr_i.op == OP_SUBROUTINE_RETURN;
    assign push = go && is_call &&
                  (depth_reg != (STACK_AW+1)'(2**STACK_AW));
    assign pop = go && is_ret && (depth_reg != '0);
    assign top_idx = STACK_AW'(depth_reg - 1'b1);

    // Saved return addresses
    return_stack #(
        .WIDTH(ADDR_W),
        .AW(STACK_AW)
    ) u_stack (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(push),
        .waddr_i(depth_reg[STACK_AW-1:0]),
        .wdata_i(instr_i.next_pc),
        .raddr_i(top_idx),
        .rdata_o(stack_rdata)
    );

    // Stack depth and error flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            depth_reg <= '0;
            ovf_reg <= 1'b0;
            unf_reg <= 1'b0;
        end else if (ce_i) begin
            if (push) begin
                depth_reg <= depth_reg + 1'b1;
            end else if (pop) begin
                depth_reg <= depth_reg - 1'b1;
            end
            if (go && is_call && !push) begin
                ovf_reg <= 1'b1;
            end else if (wb_wr && adr_i == REG_STATUS && sel_i[0] &&
                         dat_i[STAT_OVF_BIT]) begin
                ovf_reg <= 1'b0;
            end
            if (go && is_ret && !pop) begin
                unf_reg <= 1'b1;
            end else if (wb_wr && adr_i == REG_STATUS && sel_i[0] &&
                         dat_i[STAT_UNF_BIT]) begin
                unf_reg <= 1'b0;
            end
        end
    end

    // Return waits one cycle for the registered stack read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ret_pend_reg <= 1'b0;
        end else if (ce_i) begin
            ret_pend_reg <= pop;
        end
    end

    // --------------------------------------------------------------
    // Execution results
    // --------------------------------------------------------------
    logic last_c_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_we_o <= 1'b0;
            carry_o <= 1'b0;
            byte_we_o <= 1'b0;
            byte_o <= 8'h00;
            pc_we_o <= 1'b0;
            pc_o <= PC_RESET;
            done_o <= 1'b0;
            taken_reg <= 1'b0;
            last_c_reg <= 1'b0;
        end else if (ce_i) begin
            carry_we_o <= 1'b0;
            byte_we_o <= 1'b0;
            pc_we_o <= 1'b0;
            done_o <= 1'b0;
            if (ret_pend_reg) begin
                pc_we_o <= 1'b1;
                pc_o <= stack_rdata;
                done_o <= 1'b1;
                taken_reg <= 1'b1;
            end else if (go) begin
                done_o <= !pop;
                unique case (instr_i.op)
                    OP_CARRY_OR_BIT: begin
                        carry_we_o <= 1'b1;
                        carry_o <= c_in | sel_bit;
                    end
                    OP_CARRY_OR_INVERTED_BIT: begin
                        carry_we_o <= 1'b1;
                        carry_o <= c_in | !sel_bit;
                    end
                    OP_CARRY_XOR_BIT: begin
                        carry_we_o <= 1'b1;
                        carry_o <= c_in ^ sel_bit;
                    end
                    OP_CARRY_XOR_INVERTED_BIT: begin
                        carry_we_o <= 1'b1;
                        carry_o <= c_in ^ !sel_bit;
                    end
                    OP_BIT_TO_CARRY_LOAD: begin
                        carry_we_o <= 1'b1;
                        carry_o <= sel_bit;
                    end
                    OP_INVERTED_BIT_TO_CARRY_LOAD: begin
                        carry_we_o <= 1'b1;
                        carry_o <= !sel_bit;
                    end
                    OP_CARRY_TO_BIT_STORE: begin
                        byte_we_o <= 1'b1;
                        byte_o <= c_in ? (operand_i | bit_mask)
                                       : (operand_i & ~bit_mask);
                    end
                    OP_INVERTED_CARRY_TO_BIT_STORE: begin
                        byte_we_o <= 1'b1;
                        byte_o <= c_in ? (operand_i & ~bit_mask)
                                       : (operand_i | bit_mask);
                    end
                    OP_COND_BRANCH: begin
                        pc_we_o <= 1'b1;
                        pc_o <= cond_true ? instr_i.target
                                          : instr_i.next_pc;
                        taken_reg <= cond_true;
                    end
                    OP_UNCONDITIONAL_JUMP: begin
                        pc_we_o <= 1'b1;
                        pc_o <= instr_i.target;
                        taken_reg <= 1'b1;
                    end
                    OP_RELATIVE_SUBROUTINE_CALL,
                    OP_ABSOLUTE_SUBROUTINE_CALL: begin
                        pc_we_o <= push;
                        pc_o <= instr_i.target;
                        taken_reg <= push;
                    end
                    default: begin
                        pc_we_o <= 1'b0;
                    end
                endcase
                last_c_reg <= c_in;
            end
        end
    end

    // --------------------------------------------------------------
    // Wishbone register slave
    // --------------------------------------------------------------
    // Write strobe, once per bus cycle

    assign wb_wr = cyc_i && stb_i && we_i && !ack_o;

    // Control register write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg <= 1'b1;
        end else if (ce_i && wb_wr && adr_i == REG_CTRL && sel_i[0]) begin
            enable_reg <= dat_i[CTRL_ENABLE_BIT];
        end
    end

    // One-cycle acknowledge and read mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else if (ce_i) begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= 32'h00000000;
            if (cyc_i && stb_i && !we_i && !ack_o) begin
                unique case (adr_i)
                    REG_CTRL: dat_o[CTRL_ENABLE_BIT] <= enable_reg;
                    REG_STATUS: begin
                        dat_o[STAT_C_BIT] <= last_c_reg;
                        dat_o[STAT_OVF_BIT] <= ovf_reg;
                        dat_o[STAT_UNF_BIT] <= unf_reg;
                        dat_o[STAT_TAKEN_BIT] <= taken_reg;
                    end
                    REG_PC: dat_o[ADDR_W-1:0] <= pc_o;
                    REG_DEPTH: dat_o[STACK_AW:0] <= depth_reg;
                    default: dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// file: logic/return_stack.sv
// Small return-address stack memory with registered read data.
// Assumes one clock, no reset of the memory and a caller that checks depth.
`timescale 1ns/10ps
`default_nettype none

module return_stack #(
    parameter int WIDTH = 24,
    parameter int AW = 3
) (
    // Clock
    input wire logic clk_i,
    input wire logic ce_i,
    // Write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);

    logic [WIDTH-1:0] mem_reg [2**AW];

    // Write and registered read
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_reg[waddr_i] <= wdata_i;
            end
            rdata_o <= mem_reg[raddr_i];
        end
    end

endmodule

`default_nettype wire

// file: verification/carry_bit_branch_asserts.sv
// Checker for the carry bit and branch block, seen from its ports.
// Assumes bind to the top module, one clock and a sync high reset.
`timescale 1ns/10ps
`default_nettype none

module carry_bit_branch_asserts
    import bitbr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Decoder side
    input wire logic exec_i,
    input wire instr_t instr_i,
    input wire flags_t flags_i,
    input wire logic [7:0] operand_i,
    // Results
    input wire logic carry_we_o,
    input wire logic carry_o,
    input wire logic byte_we_o,
    input wire logic [7:0] byte_o,
    input wire logic pc_we_o,
    input wire logic [ADDR_W-1:0] pc_o,
    input wire logic done_o,
    // Bus handshake
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    // ------
    // Helpers
    // ------
    logic [2:0] ix;
    logic b, bi, r, tk;
    logic [7:0] mp, mi;
    assign ix = instr_i.bit_from_reg ? instr_i.bit_reg[2:0] : instr_i.bit_imm;
    assign b = operand_i[ix];
    assign bi = ~operand_i[instr_i.bit_imm];
    assign mp = 8'h01 << ix;
    assign mi = 8'h01 << instr_i.bit_imm;
    assign tk = ~r ^ instr_i.cond[0];
    // Raw condition per pair of codes
    always_comb begin
        case (instr_i.cond[3:1])
            3'h0: r = 1'b0;
            3'h1: r = flags_i.c | flags_i.z;
            3'h2: r = flags_i.c;
            3'h3: r = flags_i.z;
            3'h4: r = flags_i.v;
            3'h5: r = flags_i.n;
            3'h6: r = flags_i.n ^ flags_i.v;
            default: r = flags_i.z | (flags_i.n ^ flags_i.v);
        endcase
    end
    property p_c(op_t o, logic e);
        $past(exec_i && instr_i.op == o) && done_o |->
            carry_we_o && carry_o == e;
    endproperty

    // ------
    // Assertions
    // ------
    a_or_plain: assert property (p_c(OP_CARRY_OR_BIT,
        $past(flags_i.c | b))) else $error("carry or wrong");
    a_or_inverted: assert property (
        p_c(OP_CARRY_OR_INVERTED_BIT, $past(flags_i.c | bi)))
        else $error("carry or inverted wrong");
    a_xor_plain: assert property (p_c(OP_CARRY_XOR_BIT,
        $past(flags_i.c ^ b))) else $error("carry xor wrong");
    a_xor_inverted: assert property (p_c(OP_CARRY_XOR_INVERTED_BIT,
        $past(flags_i.c ^ bi))) else $error("carry xor inverted wrong");
    a_load_plain: assert property (p_c(OP_BIT_TO_CARRY_LOAD,
        $past(b))) else $error("bit load wrong");
    a_load_inverted: assert property (
        p_c(OP_INVERTED_BIT_TO_CARRY_LOAD, $past(bi)))
        else $error("inverted bit load wrong");
    a_store_plain: assert property ($past(exec_i
        && instr_i.op == OP_CARRY_TO_BIT_STORE) && done_o |-> byte_we_o &&
        byte_o == $past((operand_i & ~mp) | (flags_i.c ? mp : 8'h00)))
        else $error("bit store wrong");
    a_store_inverted: assert property ($past(exec_i
        && instr_i.op == OP_INVERTED_CARRY_TO_BIT_STORE) && done_o |->
        byte_we_o && byte_o ==
        $past((operand_i & ~mi) | (flags_i.c ? 8'h00 : mi)))
        else $error("inverted bit store wrong");
    a_branch_target: assert property ($past(exec_i
        && instr_i.op == OP_COND_BRANCH) && done_o |-> pc_we_o && pc_o ==
        $past(tk ? instr_i.target : instr_i.next_pc))
        else $error("branch wrong");
    a_jump_target: assert property ($past(exec_i
        && instr_i.op == OP_UNCONDITIONAL_JUMP) && done_o |-> pc_we_o
        && pc_o == $past(instr_i.target)) else $error("jump wrong");
    a_call_target: assert property (pc_we_o && $past(exec_i &&
        (instr_i.op == OP_RELATIVE_SUBROUTINE_CALL ||
        instr_i.op == OP_ABSOLUTE_SUBROUTINE_CALL)) |->
        pc_o == $past(instr_i.target)) else $error("call wrong");
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack long");
    c_branch: cover property (done_o && pc_we_o);
    c_store: cover property (done_o && !carry_we_o && !pc_we_o);
    c_bus: cover property (ack_o);
endmodule

bind carry_bit_branch carry_bit_branch_asserts u_carry_bit_branch_asserts (
    .clk_i, .rst_i, .ce_i, .exec_i, .instr_i, .flags_i, .operand_i,
    .carry_we_o, .carry_o, .byte_we_o, .byte_o, .pc_we_o, .pc_o, .done_o,
    .cyc_i, .stb_i, .ack_o);
`default_nettype wire

// file: verification/carry_bit_branch_tb_top.sv
// Self-checking bench for the carry bit and branch block.
// Assumes the checker is bound in; drives ports at the rising edge.
`timescale 1ns/10ps
`default_nettype none

module carry_bit_branch_tb_top import bitbr_pkg::*;;
    logic clk_i, rst_i, ce_i, exec_i, cyc_i, stb_i, we_i;
    instr_t instr_i, ni;
    flags_t flags_i, nf;
    logic [7:0] operand_i, nd, byte_o;
    logic [3:0] adr_i, sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic carry_we_o, carry_o, byte_we_o, pc_we_o, done_o, ack_o, ok;
    logic [ADDR_W-1:0] pc_o;
    int fails, checked;

    carry_bit_branch u_carry_bit_branch (.clk_i, .rst_i, .ce_i, .exec_i,
        .instr_i, .flags_i, .operand_i, .carry_we_o, .carry_o, .byte_we_o,
        .byte_o, .pc_we_o, .pc_o, .done_o, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o);

    // ------
    // Shared tasks
    // ------
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] s = 4'hf);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 8) begin
                fails++;
                results();
            end
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    // One instruction, then wait for done under a bound
    task automatic go(input bit need = 1'b1);
        @(posedge clk_i);
        exec_i <= 1'b1;
        instr_i <= ni;
        flags_i <= nf;
        operand_i <= nd;
        @(posedge clk_i);
        exec_i <= 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge clk_i);
            ok = (done_o === 1'b1);
        end
        if (need && !ok) begin
            fails++;
            results();
        end
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_regs();
        wb(0, REG_CTRL, 0);
        chk("ctrl", q, 32'h1);
        wb(0, REG_DEPTH, 0);
        chk("depth", q, 32'h0);
        wb(0, 4'h2, 0);
        chk("unmapped", q, 32'h0);
        wb(1, REG_CTRL, 0, 4'he);
        wb(0, REG_CTRL, 0);
        chk("sel gated", q, 32'h1);
        wb(1, REG_CTRL, 0);
        ni = '0;
        ni.op = OP_UNCONDITIONAL_JUMP;
        go(1'b0);
        chk("gated", ok, 0);
        wb(1, REG_CTRL, 1);
        $display("test regs over");
    endtask
    task automatic t_bits();
        logic [2:0] ix;
        logic b, e;
        logic [7:0] m;
        for (int o = 1; o <= 8; o++) begin
            for (int k = 0; k < 8; k++) begin
                ni = '0;
                ni.op = op_t'(5'(o));
                ni.bit_imm = 3'(k);
                ni.bit_from_reg = k[1];
                ni.bit_reg = 8'(15 - k);
                nf = '0;
                nf.c = k[0] ^ k[2];
                nd = 8'h5a;
                ix = (o % 2 == 0 || !k[1]) ? 3'(k) : 3'(7 - k);
                b = nd[ix] ^ (o % 2 == 0);
                case ((o + 1) / 2)
                    1: e = nf.c | b;
                    2: e = nf.c ^ b;
                    3: e = b;
                    default: e = nf.c ^ (o == 8);
                endcase
                go();
                chk("done", ok, 1);
                chk("carry we", carry_we_o, o < 7);
                chk("byte we", byte_we_o, o >= 7);
                if (o < 7) begin
                    chk("carry", carry_o, e);
                end else begin
                    m = nd;
                    m[ix] = e;
                    chk("byte", byte_o, m);
                end
            end
        end
        $display("test bits over");
    endtask
    task automatic t_branch();
        logic r;
        logic [ADDR_W-1:0] e;
        for (int cc = 0; cc < 16; cc++) begin
            for (int f = 0; f < 16; f++) begin
                ni = '0;
                ni.op = OP_COND_BRANCH;
                ni.cond = cond_t'(4'(cc));
                ni.target = 24'(24'h00a000 + cc);
                ni.next_pc = 24'(24'h000100 + f);
                nf = flags_t'(4'(f));
                case (cc / 2)
                    0: r = 0;
                    1: r = nf.c | nf.z;
                    2: r = nf.c;
                    3: r = nf.z;
                    4: r = nf.v;
                    5: r = nf.n;
                    6: r = nf.n ^ nf.v;
                    default: r = nf.z | (nf.n ^ nf.v);
                endcase
                e = (~r ^ cc[0]) ? ni.target : ni.next_pc;
                go();
                chk("branch we", pc_we_o, 1);
                chk("branch", pc_o, e);
            end
        end
        $display("test branch over");
    endtask
    task automatic t_flow();
        ni = '0;
        ni.op = OP_UNCONDITIONAL_JUMP;
        ni.target = 24'h123456;
        nf = 4'hf;
        go();
        chk("jump", pc_o, 24'h123456);
        for (int i = 0; i < 9; i++) begin
            ni.op = i[0] ? OP_ABSOLUTE_SUBROUTINE_CALL
                : OP_RELATIVE_SUBROUTINE_CALL;
            ni.target = 24'(24'h200000 + i);
            ni.next_pc = 24'(16 * (i + 1));
            go();
            chk("call we", pc_we_o, i < 8);
        end
        wb(0, REG_DEPTH, 0);
        chk("depth full", q, 32'h8);
        ni.op = OP_SUBROUTINE_RETURN;
        for (int i = 7; i >= -1; i--) begin
            go();
            chk("ret done", ok, 1);
            if (i >= 0) begin
                chk("ret pc", pc_o, 24'(16 * (i + 1)));
            end else begin
                chk("ret empty", pc_we_o, 0);
            end
        end
        wb(0, REG_STATUS, 0);
        chk("ovf unf", q[2:1], 2'h3);
        wb(1, REG_STATUS, 32'h6);
        wb(0, REG_STATUS, 0);
        chk("cleared", q[2:1], 2'h0);
        $display("test flow over");
    endtask
    // Clock enable low freezes a pending jump until it returns high
    task automatic t_hold();
        ni = '0;
        ni.op = OP_UNCONDITIONAL_JUMP;
        ni.target = 24'h0000aa;
        @(posedge clk_i);
        ce_i <= 1'b0;
        exec_i <= 1'b1;
        instr_i <= ni;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("frozen done", done_o, 0);
        chk("frozen pc", pc_o, 24'h000010);
        @(posedge clk_i);
        ce_i <= 1'b1;
        @(posedge clk_i);
        exec_i <= 1'b0;
        @(negedge clk_i);
        chk("thawed done", done_o, 1);
        chk("thawed pc", pc_o, 24'h0000aa);
        $display("test hold over");
    endtask

    // ------
    // Clock and main sequence
    // ------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, ce_i} = 2'h3;
        {exec_i, cyc_i, stb_i, we_i} = 4'h0;
        instr_i = '0;
        flags_i = '0;
        operand_i = 8'h00;
        adr_i = 4'h0;
        sel_i = 4'hf;
        dat_i = 32'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_bits();
        t_branch();
        t_flow();
        t_hold();
        results();
    end
endmodule
`default_nettype wire
